// *** common/nvmpsc_regs.vh ***
`ifndef NVMPSC_REGS_VH
`define NVMPSC_REGS_VH
// Register byte offsets on the AHB-Lite slave.
`define NVMPSC_OFS_PROT      6'h00
`define NVMPSC_OFS_STAT      6'h04
`define NVMPSC_OFS_CMD       6'h08
`define NVMPSC_OFS_DIV       6'h0C
`define NVMPSC_OFS_IRQ_STAT  6'h10
`define NVMPSC_OFS_IRQ_CLR   6'h14
`define NVMPSC_OFS_IRQ_EN    6'h18
`define NVMPSC_OFS_ADDR      6'h1C
// Protection register fields.
`define NVMPSC_EESEL_HI      7
`define NVMPSC_EESEL_LO      6
`define NVMPSC_ARRSEL_HI     5
`define NVMPSC_ARRSEL_LO     0
`define NVMPSC_EESEL_NONE    2'h3
`define NVMPSC_ARRSEL_NONE   6'h3F
`define NVMPSC_ARRSEL_FULL   6'h18
`define NVMPSC_EE_TOP        16'h17FF
`define NVMPSC_EE_LO2        16'h17F0
`define NVMPSC_EE_LO1        16'h17E0
`define NVMPSC_EE_LO0        16'h17C0
`define NVMPSC_FL_STEP       17'h0_0600
`define NVMPSC_FL_END        17'h1_0000
// Status register bit positions.
`define NVMPSC_ST_CBE        7
`define NVMPSC_ST_CCF        6
`define NVMPSC_ST_PV         5
`define NVMPSC_ST_AE         4
`define NVMPSC_ST_BLANK      2
// Interrupt status bit positions.
`define NVMPSC_IRQ_CCF       0
`define NVMPSC_IRQ_PV        1
`define NVMPSC_IRQ_AE        2
// Command codes.
`define NVMPSC_CMD_BLANK     8'h05
`define NVMPSC_CMD_BYTE      8'h20
`define NVMPSC_CMD_BURST     8'h25
`define NVMPSC_CMD_SECT      8'h40
`define NVMPSC_CMD_MASS      8'h41
`define NVMPSC_CMD_ABORT     8'h47
// AHB transfer type bit that marks an active transfer.
`define NVMPSC_HTRANS_ACT    1
`endif

// *** hdl/nvmpsc_core.v ***
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "nvmpsc_regs.vh"

// Overview of operation
// (R01) Bits 7:6 pick the protected top EEPROM region; value 3 protects nothing.
// (R02) Bits 5:0 pick protected top Flash; each step adds 1.5K, 0x18 and below all.
// (R03) Writing one to buffer-empty launches a command and clears the flag.
// (R04) Only burst programs are buffered; buffer-empty low while the buffer is full.
// (R05) Complete flag set when idle and empty, cleared on launch, writes ignored.
// (R06) Program or erase to a protected place sets violation, is dropped; write one clears.
// (R07) Any break of the command write sequence sets access error and drops the command.
// (R08) Program or erase before the divider was ever written is an access error.
// (R09) Entering stop while a command runs is an access error.
// (R10) Writing one clears access error; writing zero does nothing.
// (R11) Blank flag set when a blank check finds all erased; cleared on a valid launch.
// (R12) Six command codes are accepted; byte and burst program differ in low bits.
// (R13) Any other command code raises access error.
// (R14) Software need not blank check after mass erase, only to unlock security.
// (R15) Protection register loads from its stored copy during reset.
// (R16) Writes that shrink the protected region are ignored.
// (R17) Mass erase is refused while any sector is protected.
// (R18) Undefined status bits read zero and ignore writes.
module nvmpsc_core (
    input  wire        clk,
    input  wire        srst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire [7:0]  stored_protection_copy,
    input  wire        stop_entry,
    output reg         arr_start,
    output reg         arr_abort,
    output reg  [7:0]  arr_cmd,
    output reg  [15:0] arr_addr,
    input  wire        arr_done,
    input  wire        arr_blank,
    output wire        irq
);

    // Start of the lowest protected Flash byte; one bit wider than an address to hold "none".
    function [16:0] fl_lo;
        input [5:0] sel;
        begin
            if (sel <= `NVMPSC_ARRSEL_FULL) begin
                fl_lo = 17'h0_0000;
            end else begin
                fl_lo = `NVMPSC_FL_END - (`NVMPSC_FL_STEP * {11'h000, `NVMPSC_ARRSEL_NONE - sel});
            end
        end
    endfunction

    // Start of the lowest protected EEPROM byte; 0x1_0000 means nothing.
    function [16:0] ee_lo;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    ee_lo = {1'b0, `NVMPSC_EE_LO0};
                2'h1:    ee_lo = {1'b0, `NVMPSC_EE_LO1};
                2'h2:    ee_lo = {1'b0, `NVMPSC_EE_LO2};
                default: ee_lo = `NVMPSC_FL_END;
            endcase
        end
    endfunction

    reg  [7:0]  prot_q;
    reg  [7:0]  cmd_q;
    reg  [15:0] addr_q;
    reg  [7:0]  div_q;
    reg         div_wr_q;
    reg  [1:0]  seq_q;
    reg         cbe_q;
    reg         ccf_q;
    reg         pv_q;
    reg         ae_q;
    reg         blank_q;
    reg         active_q;
    reg  [7:0]  act_cmd_q;
    reg         buf_valid_q;
    reg  [15:0] buf_addr_q;
    reg  [2:0]  irq_stat_q;
    reg  [2:0]  irq_en_q;
    reg         ccf_prev_q;
    reg         wr_pend_q;
    reg  [5:0]  wr_ofs_q;

    // Command write sequence states; a launch is only legal from the last one.
    localparam [1:0] SEQ_IDLE = 2'h0;
    localparam [1:0] SEQ_ADDR = 2'h1;
    localparam [1:0] SEQ_CMD  = 2'h2;

    wire        addr_act = hsel & hready & htrans[`NVMPSC_HTRANS_ACT];
    wire        wr_stat  = wr_pend_q & (wr_ofs_q == `NVMPSC_OFS_STAT);
    wire        wr_cmd   = wr_pend_q & (wr_ofs_q == `NVMPSC_OFS_CMD);
    wire        wr_addr  = wr_pend_q & (wr_ofs_q == `NVMPSC_OFS_ADDR);
    wire        wr_prot  = wr_pend_q & (wr_ofs_q == `NVMPSC_OFS_PROT);
    wire        wr_div   = wr_pend_q & (wr_ofs_q == `NVMPSC_OFS_DIV);
    wire        wr_iclr  = wr_pend_q & (wr_ofs_q == `NVMPSC_OFS_IRQ_CLR);
    wire        wr_ien   = wr_pend_q & (wr_ofs_q == `NVMPSC_OFS_IRQ_EN);
    wire [7:0]  wd       = hwdata[7:0];
    wire        launch   = wr_stat & wd[`NVMPSC_ST_CBE] & cbe_q;
    wire [1:0]  ee_sel   = prot_q[`NVMPSC_EESEL_HI:`NVMPSC_EESEL_LO];
    wire [5:0]  arr_sel  = prot_q[`NVMPSC_ARRSEL_HI:`NVMPSC_ARRSEL_LO];
    wire [16:0] tgt      = {1'b0, addr_q};

    // Command decode for the pending code and the launch decision.
    reg         legal;
    reg         is_pe;
    reg         prot_hit;
    reg         seq_err;
    reg         ae_evt;
    reg         pv_evt;
    reg         go;
    always @* begin
        legal = (wd == `NVMPSC_CMD_BLANK) | (wd == `NVMPSC_CMD_BYTE) |
                (wd == `NVMPSC_CMD_BURST) | (wd == `NVMPSC_CMD_SECT) |
                (wd == `NVMPSC_CMD_MASS)  | (wd == `NVMPSC_CMD_ABORT); // (R12)
        is_pe = (cmd_q == `NVMPSC_CMD_BYTE) | (cmd_q == `NVMPSC_CMD_BURST) |
                (cmd_q == `NVMPSC_CMD_SECT) | (cmd_q == `NVMPSC_CMD_MASS);
        prot_hit = ((tgt >= ee_lo(ee_sel)) & (addr_q <= `NVMPSC_EE_TOP)) |
                   (tgt >= fl_lo(arr_sel)); // (R01) (R02)
        if (cmd_q == `NVMPSC_CMD_MASS) begin
            prot_hit = (ee_sel != `NVMPSC_EESEL_NONE) |
                       (arr_sel != `NVMPSC_ARRSEL_NONE); // (R17)
        end
        // Address and command writes are only legal while the buffer has room.
        seq_err = ((wr_addr | wr_cmd) & ~cbe_q) |
                  (wr_cmd & (seq_q != SEQ_ADDR)) |
                  (launch & (seq_q != SEQ_CMD)); // (R07)
        ae_evt = seq_err | (wr_cmd & ~legal) | (stop_entry & active_q); // (R13) (R09)
        if (launch & ~seq_err) begin
            if (is_pe & ~div_wr_q) begin
                ae_evt = 1'b1; // (R08)
            end
            // While busy only a burst behind a burst, or an abort behind a sector erase, may launch.
            if (active_q & ~((cmd_q == `NVMPSC_CMD_BURST) &
                             (act_cmd_q == `NVMPSC_CMD_BURST)) &
                ~((cmd_q == `NVMPSC_CMD_ABORT) & (act_cmd_q == `NVMPSC_CMD_SECT))) begin
                ae_evt = 1'b1; // (R04)
            end
        end
        pv_evt = launch & ~ae_evt & is_pe & prot_hit; // (R06)
        go = launch & ~ae_evt & ~pv_evt;
    end

    // AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always @(posedge clk) begin
        if (srst) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q  <= 6'h00;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend_q <= addr_act & hwrite & (haddr[31:6] == 26'h000_0000);
            wr_ofs_q  <= haddr[5:0];
            hrdata    <= 32'h0000_0000;
            if (addr_act & ~hwrite & (haddr[31:6] == 26'h000_0000)) begin
                case (haddr[5:0])
                    `NVMPSC_OFS_PROT:     hrdata[7:0] <= prot_q;
                    `NVMPSC_OFS_STAT:     hrdata[7:0] <= {cbe_q, ccf_q, pv_q, ae_q,
                                                          1'b0, blank_q, 2'h0}; // (R18)
                    `NVMPSC_OFS_CMD:      hrdata[7:0] <= cmd_q;
                    `NVMPSC_OFS_DIV:      hrdata[7:0] <= div_q;
                    `NVMPSC_OFS_IRQ_STAT: hrdata[2:0] <= irq_stat_q;
                    `NVMPSC_OFS_IRQ_EN:   hrdata[2:0] <= irq_en_q;
                    `NVMPSC_OFS_ADDR:     hrdata[15:0] <= addr_q;
                    default:              hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software-owned registers and the command write sequence.
    always @(posedge clk) begin
        if (srst) begin
            prot_q   <= stored_protection_copy; // (R15)
            cmd_q    <= 8'h00;
            addr_q   <= 16'h0000;
            div_q    <= 8'h00;
            div_wr_q <= 1'b0;
            seq_q    <= SEQ_IDLE;
            irq_en_q <= 3'h0;
        end else begin
            // Smaller codes mean larger regions, so each field may only go down.
            if (wr_prot & (wd[7:6] <= ee_sel) & (wd[5:0] <= arr_sel)) begin
                prot_q <= wd; // (R16)
            end
            if (wr_div) begin
                div_q    <= wd;
                div_wr_q <= 1'b1;
            end
            if (wr_ien) begin
                irq_en_q <= wd[2:0];
            end
            if (ae_evt | launch) begin
                seq_q <= SEQ_IDLE; // (R07)
            end else if (wr_addr) begin
                addr_q <= hwdata[15:0];
                seq_q  <= SEQ_ADDR;
            end else if (wr_cmd) begin
                cmd_q <= wd;
                seq_q <= SEQ_CMD;
            end
        end
    end

    // Status flags; a hardware set wins over a write-one clear in the same cycle, but a launch clears complete.
    always @(posedge clk) begin
        if (srst) begin
            cbe_q   <= 1'b1;
            ccf_q   <= 1'b1;
            pv_q    <= 1'b0;
            ae_q    <= 1'b0;
            blank_q <= 1'b0;
        end else begin
            if (launch) begin
                cbe_q <= 1'b0; // (R03)
            end else if (~cbe_q & ~buf_valid_q) begin
                cbe_q <= 1'b1; // (R04)
            end
            if (launch) begin
                ccf_q <= 1'b0; // (R05)
            end else begin
                ccf_q <= cbe_q & ~active_q & ~buf_valid_q; // (R05)
            end
            if (pv_evt) begin
                pv_q <= 1'b1; // (R06)
            end else if (wr_stat & wd[`NVMPSC_ST_PV]) begin
                pv_q <= 1'b0; // (R06)
            end
            if (ae_evt) begin
                ae_q <= 1'b1; // (R07)
            end else if (wr_stat & wd[`NVMPSC_ST_AE]) begin
                ae_q <= 1'b0; // (R10)
            end
            if (arr_done & active_q & (act_cmd_q == `NVMPSC_CMD_BLANK)) begin
                blank_q <= arr_blank; // (R11)
            end else if (go) begin
                blank_q <= 1'b0; // (R11)
            end
        end
    end

    // Array sequencer with a one-deep buffer for burst programs.
    always @(posedge clk) begin
        if (srst) begin
            active_q    <= 1'b0;
            act_cmd_q   <= 8'h00;
            buf_valid_q <= 1'b0;
            buf_addr_q  <= 16'h0000;
            arr_start   <= 1'b0;
            arr_abort   <= 1'b0;
            arr_cmd     <= 8'h00;
            arr_addr    <= 16'h0000;
        end else begin
            arr_start <= 1'b0;
            arr_abort <= 1'b0;
            if (arr_done & active_q) begin
                if (buf_valid_q) begin
                    arr_start   <= 1'b1; // (R03)
                    arr_addr    <= buf_addr_q;
                    buf_valid_q <= 1'b0;
                end else begin
                    active_q <= 1'b0;
                end
            end
            if (go & active_q & (cmd_q == `NVMPSC_CMD_ABORT)) begin
                arr_abort <= 1'b1;
            end else if (go & active_q) begin
                buf_valid_q <= 1'b1; // (R04)
                buf_addr_q  <= addr_q;
            end else if (go) begin
                active_q  <= 1'b1;
                act_cmd_q <= cmd_q;
                arr_start <= 1'b1;
                arr_cmd   <= cmd_q;
                arr_addr  <= addr_q;
            end
        end
    end

    // Interrupts: sticky events, write-one-to-clear, set beats clear.
    wire [2:0] irq_evt = {ae_evt, pv_evt, ccf_q & ~ccf_prev_q};
    always @(posedge clk) begin
        if (srst) begin
            irq_stat_q <= 3'h0;
            ccf_prev_q <= 1'b1;
        end else begin
            ccf_prev_q <= ccf_q;
            irq_stat_q <= irq_evt | (irq_stat_q & ~(wr_iclr ? wd[2:0] : 3'h0));
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

endmodule

// *** dv/nvmpsc_asserts.sv ***
`timescale 1ns/1ns
`include "nvmpsc_regs.vh"

// Watches the core's ports; it keeps the last protection read back and whether the divider was set.
module nvmpsc_asserts (
    input logic        clk,
    input logic        srst,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic        hresp,
    input logic [7:0]  stored_protection_copy,
    input logic        arr_start,
    input logic [7:0]  arr_cmd,
    input logic [15:0] arr_addr
);
    logic       acc;
    logic       rdp_q;
    logic       wdiv_q;
    logic       div_q;
    logic [7:0] prot_q;

    // An address phase that the slave takes.
    assign acc = hsel && hready && htrans[`NVMPSC_HTRANS_ACT];

    // Protection only grows, so the last value read is a safe lower bound on what is locked.
    always_ff @(posedge clk) begin
        if (srst) begin
            prot_q <= stored_protection_copy;
            rdp_q  <= 1'b0;
            wdiv_q <= 1'b0;
            div_q  <= 1'b0;
        end else begin
            rdp_q  <= acc && !hwrite && haddr == {26'h0, `NVMPSC_OFS_PROT};
            wdiv_q <= acc && hwrite && haddr == {26'h0, `NVMPSC_OFS_DIV};
            if (rdp_q)
                prot_q <= hrdata[7:0];
            if (wdiv_q)
                div_q <= 1'b1;
        end
    end

    // True when address a lies in the region that protection value p locks.
    function automatic logic hit(input logic [7:0] p, input logic [15:0] a);
        logic [16:0] fs;
        logic [15:0] es;
        fs = `NVMPSC_FL_END - (17'h0_003F - {11'h0, p[5:0]}) * `NVMPSC_FL_STEP;
        es = p[7] ? `NVMPSC_EE_LO2 : (p[6] ? `NVMPSC_EE_LO1 : `NVMPSC_EE_LO0);
        hit = (p[7:6] != `NVMPSC_EESEL_NONE && a <= `NVMPSC_EE_TOP && a >= es) ||
              (p[5:0] != `NVMPSC_ARRSEL_NONE &&
               (p[5:0] <= `NVMPSC_ARRSEL_FULL || {1'b0, a} >= fs));
    endfunction

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_rd(logic [5:0] ofs);
        acc && !hwrite && haddr == {26'h0, ofs};
    endsequence

    a_stat_resv: assert property (s_rd(`NVMPSC_OFS_STAT) |=> hrdata[31:8] == 24'h0
        && hrdata[3] == 1'b0 && hrdata[1:0] == 2'h0) else $error("status reserved bits set");
    a_cmpl_empty: assert property (s_rd(`NVMPSC_OFS_STAT) |=> hrdata[7] || !hrdata[6])
        else $error("complete shown while buffer full");
    a_prot_grow: assert property (s_rd(`NVMPSC_OFS_PROT) |=> hrdata[31:8] == 24'h0
        && hrdata[7:6] <= prot_q[7:6] && hrdata[5:0] <= prot_q[5:0]) else $error("protection shrank");
    a_mass_refuse: assert property (arr_start && arr_cmd == `NVMPSC_CMD_MASS |-> prot_q == 8'hFF)
        else $error("mass erase started while protected");
    a_prot_block: assert property (arr_start && arr_cmd inside {`NVMPSC_CMD_BYTE,
        `NVMPSC_CMD_BURST, `NVMPSC_CMD_SECT} |-> !hit(prot_q, arr_addr)) else $error("protected target");
    a_div_first: assert property (arr_start && arr_cmd != `NVMPSC_CMD_BLANK |-> div_q)
        else $error("program or erase before divider write");
    a_cmd_legal: assert property (arr_start |-> arr_cmd inside {`NVMPSC_CMD_BLANK,
        `NVMPSC_CMD_BYTE, `NVMPSC_CMD_BURST, `NVMPSC_CMD_SECT, `NVMPSC_CMD_MASS})
        else $error("illegal command started");
    a_start_pulse: assert property (arr_start |=> !arr_start)
        else $error("start longer than one cycle");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
endmodule

bind nvmpsc_core nvmpsc_asserts u_chk (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .stored_protection_copy(stored_protection_copy), .arr_start(arr_start),
    .arr_cmd(arr_cmd), .arr_addr(arr_addr));

// *** dv/tb_nvm_protect_status_command.sv ***
`timescale 1ns/1ns
`include "nvmpsc_regs.vh"

// Bus master and array stand-in for the core; expected values are fixed by the tests.
module tb_nvm_protect_status_command;
    localparam logic [5:0] ST = `NVMPSC_OFS_STAT;
    localparam logic [5:0] PR = `NVMPSC_OFS_PROT;
    logic        clk = 0, srst = 1, hsel = 0, hwrite = 0, hready, stop = 0, done = 0, blank = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0]  htrans = 0;
    logic [7:0]  pcopy = 0;
    wire         hreadyout, arr_start, arr_abort, irq;
    wire  [31:0] hrdata;
    wire  [7:0]  arr_cmd;
    wire  [15:0] arr_addr;
    int          mismatches = 0, comparisons = 0, cycles = 0;
    logic [7:0]  bad [4] = '{8'h00, 8'h21, 8'h46, 8'hFF};
    logic [16:0] tgt [6] = '{17'h0_1000, 17'h0_EDFF, 17'h1_EE00, 17'h0_17DF, 17'h1_17E0, 17'h1_17FF};

    nvmpsc_core dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(), .hrdata(hrdata), .stored_protection_copy(pcopy), .stop_entry(stop),
        .arr_start(arr_start), .arr_abort(arr_abort), .arr_cmd(arr_cmd), .arr_addr(arr_addr),
        .arr_done(done), .arr_blank(blank), .irq(irq));

    // The single slave's ready is the bus's ready.
    assign hready = hreadyout;

    always #20 clk = ~clk;

    // Cuts a hang short well past the few hundred cycles the tests take.
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One AHB single transfer; the address phase is held until ready is seen high.
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(a, 1'b1, {24'h0, d}, r);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r & {24'hFF_FFFF, m}, {24'h0, e & m});
    endtask

    // Address, code, launch; then look for a start or an abort on the array side.
    task automatic launch(input logic [15:0] a, input logic [7:0] c, input logic st);
        logic [31:0] r;
        logic        got;
        got = 1'b0;
        bus(`NVMPSC_OFS_ADDR, 1'b1, {16'h0, a}, r);
        wr(`NVMPSC_OFS_CMD, c);
        wr(ST, 8'h80);
        repeat (4) begin
            @(posedge clk);
            got = got | arr_start | arr_abort;
            if (arr_start === 1'b1)
                chk({8'h0, arr_cmd, arr_addr}, {8'h0, c, a});
        end
        chk({31'h0, got}, {31'h0, st});
    endtask

    task automatic fin(input logic b);
        blank <= b;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic irqchk(input logic e);
        @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic rst(input logic [7:0] p);
        pcopy <= p;
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    // Main sequence; status values are buffer empty, complete, violation, error and blank.
    initial begin
        rst(8'h7D);
        rd(PR, 8'h7D);
        rd(ST, 8'hC0);
        rd(6'h20, 8'h00);
        wr(PR, 8'hFF);
        rd(PR, 8'h7D);
        wr(PR, 8'h7C);
        rd(PR, 8'h7C);
        $display("Test protection register done");
        launch(16'h1000, `NVMPSC_CMD_BYTE, 1'b0);
        rd(ST, 8'hD0);
        irqchk(1'b0);
        wr(`NVMPSC_OFS_IRQ_EN, 8'h04);
        irqchk(1'b1);
        rd(`NVMPSC_OFS_IRQ_STAT, 8'h04, 8'h04);
        wr(ST, 8'h00);
        rd(ST, 8'hD0);
        wr(ST, 8'h1F);
        rd(ST, 8'hC0);
        irqchk(1'b1);
        wr(`NVMPSC_OFS_IRQ_CLR, 8'h04);
        irqchk(1'b0);
        wr(`NVMPSC_OFS_CMD, `NVMPSC_CMD_BYTE);
        rd(ST, 8'h10, 8'h10);
        foreach (bad[i]) begin
            wr(ST, 8'h10);
            launch(16'h1000, bad[i], 1'b0);
            rd(ST, 8'h10, 8'h10);
        end
        wr(ST, 8'h10);
        $display("Test access errors done");
        wr(`NVMPSC_OFS_DIV, 8'h13);
        foreach (tgt[i]) begin
            launch(tgt[i][15:0], `NVMPSC_CMD_SECT, !tgt[i][16]);
            if (!tgt[i][16])
                fin(1'b0);
            rd(ST, tgt[i][16] ? 8'hE0 : 8'hC0);
            wr(ST, 8'h20);
        end
        launch(16'h0000, `NVMPSC_CMD_MASS, 1'b0);
        rd(ST, 8'hE0);
        wr(ST, 8'h20);
        $display("Test protection checks done");
        launch(16'h2000, `NVMPSC_CMD_BURST, 1'b1);
        rd(ST, 8'h80);
        launch(16'h2001, `NVMPSC_CMD_BURST, 1'b0);
        rd(ST, 8'h00);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
        chk({15'h0, arr_start, arr_addr}, {15'h0, 1'b1, 16'h2001});
        rd(ST, 8'h80);
        fin(1'b0);
        rd(ST, 8'hC0);
        $display("Test burst buffering done");
        launch(16'h0000, `NVMPSC_CMD_BLANK, 1'b1);
        fin(1'b1);
        rd(ST, 8'hC4);
        launch(16'h1000, `NVMPSC_CMD_BYTE, 1'b1);
        rd(ST, 8'h80);
        fin(1'b0);
        launch(16'h3000, `NVMPSC_CMD_SECT, 1'b1);
        launch(16'h3000, `NVMPSC_CMD_ABORT, 1'b1);
        fin(1'b0);
        rd(ST, 8'hC0);
        launch(16'h3000, `NVMPSC_CMD_SECT, 1'b1);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        rd(ST, 8'h10, 8'h10);
        fin(1'b0);
        wr(ST, 8'h10);
        $display("Test blank abort stop done");
        rst(8'hFF);
        rd(PR, 8'hFF);
        wr(`NVMPSC_OFS_DIV, 8'h01);
        launch(16'h0000, `NVMPSC_CMD_MASS, 1'b1);
        fin(1'b0);
        rd(ST, 8'hC0);
        $display("Test second reset done");
        summarize();
    end
endmodule
